/* core/mbsf_map.vh */
// Function
// - Single-address mode answers RTU requests on one configured slave address.
// - Multi-address mode answers only requests matching the addressed point's own address; TCP requests are matched on port alone.
// - TCP requests on the configured port get the same register data.
// - Baud, parity and stop bits are configurable; both ends must match.
// - Wait the configured millisecond delay after a request before responding.
// - Unmapped read with zero-fill option returns zero.
// - Unmapped read with silent option sends no response.
// - Unmapped write is never answered.
// - Float format spreads a single-precision value over two 16-bit registers.
// - Rounded format gives the nearest integer in one 16-bit register.
// - Scaled format gives gain times value minus (offset minus 32768).
// - Swapped option exchanges the high and low float registers.
// - Status-as-error replaces the value on critical failure status.
// - Float error value is NaN, +Inf, -Inf or user value.
// - Integer formats substitute a separate user integer error value.
// - Scaling uses a configurable maximum integer, default 65534.
// - A switch selects global or per-value gain and offset.
// - Partial discrete transfers are packed toward the most significant bit.
`ifndef MBSF_MAP_VH
`define MBSF_MAP_VH

// ----------------------------------------
// Formats and error choices
// ----------------------------------------
`define MBSF_FMT_FLOAT    2'h0
`define MBSF_FMT_ROUND    2'h1
`define MBSF_FMT_SCALE    2'h2
`define MBSF_ERR_NAN      2'h0
`define MBSF_ERR_PINF     2'h1
`define MBSF_ERR_NINF     2'h2
`define MBSF_ERR_USER     2'h3
`define MBSF_F32_NAN      32'h7FC00000
`define MBSF_F32_PINF     32'h7F800000
`define MBSF_F32_NINF     32'hFF800000

// ----------------------------------------
// Scaling and timing
// ----------------------------------------
`define MBSF_SCALE_BIAS   32768
`define MBSF_MAXINT_RST   16'hFFFE
`define MBSF_CLK_MHZ      200
`define MBSF_CYC_PER_MS   (`MBSF_CLK_MHZ * 1000)
`define MBSF_BAUD_RST     16'h2580
`define MBSF_TCP_PORT_RST 16'h01F6

`endif

/* core/mbsf_conv.v */
`timescale 1ns/10ps
`include "mbsf_map.vh"
// ----------------------------------------
// Value converter: float to round/scale
// ----------------------------------------
// Combinational; input is IEEE single. Scale: y = A*x - (B - 32768),
// gain and offset are signed 16.16 fixed point and integer.
module mbsf_conv (
    input  wire [31:0] value_in,
    input  wire [31:0] gain_in,
    input  wire [31:0] offset_in,
    input  wire [15:0] max_int_in,
    output reg  [15:0] round_out,
    output reg  [15:0] scale_out
);
    reg        [7:0]  exp_v;
    reg        [23:0] mant_v;
    reg signed [47:0] fix_v;
    reg signed [47:0] rnd_v;
    reg signed [79:0] prod_v;
    reg signed [47:0] y_v;

    // Float to signed 32.16 fixed point, then round and scale
    always @* begin
        exp_v  = value_in[30:23];
        mant_v = {1'b1, value_in[22:0]};
        fix_v  = 48'sh0;
        if (exp_v >= 8'h67 && exp_v < 8'h9E) begin
            if (exp_v >= 8'h86)
                fix_v = $signed({24'h0, mant_v}) <<< (exp_v - 8'h86);
            else
                fix_v = $signed({24'h0, mant_v}) >>> (8'h86 - exp_v);
        end else if (exp_v >= 8'h9E) begin
            fix_v = 48'sh7FFFFFFF0000;
        end
        if (value_in[31])
            fix_v = -fix_v;
        // Nearest integer, half away from zero
        rnd_v = value_in[31] ? -((-fix_v + 48'sh8000) >>> 16) : ((fix_v + 48'sh8000) >>> 16);
        round_out = rnd_v[15:0];
        prod_v = fix_v * $signed(gain_in);
        y_v = $signed(prod_v[79:32]) - ($signed({{16{offset_in[31]}}, offset_in})
              - 48'sh8000);
        // Clamp into 0..max
        if (y_v < 48'sh0)
            scale_out = 16'h0000;
        else if (y_v > $signed({32'h0, max_int_in}))
            scale_out = max_int_in;
        else
            scale_out = y_v[15:0];
    end
endmodule

/* core/mbsf_delay.v */
`timescale 1ns/10ps
`include "mbsf_map.vh"
// ----------------------------------------
// Response delay timer in milliseconds
// ----------------------------------------
module mbsf_delay #(
    parameter CYC_PER_MS = `MBSF_CYC_PER_MS
) (
    input  wire        clock_in,
    input  wire        nrst_in,
    input  wire        ce_in,
    input  wire        start_in,
    input  wire [15:0] delay_ms_in,
    output wire        done_out
);
    reg [31:0] cyc_q;
    reg [15:0] ms_q;
    reg        run_q;
    reg        done_q;

    assign done_out = done_q;

    // Count whole milliseconds, pulse done when reached
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cyc_q  <= 32'h0;
            ms_q   <= 16'h0;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end else if (ce_in) begin
            done_q <= 1'b0;
            if (start_in) begin
                cyc_q <= 32'h0;
                ms_q  <= 16'h0;
                run_q <= 1'b1;
            end else if (run_q) begin
                if (ms_q == delay_ms_in) begin
                    run_q  <= 1'b0;
                    done_q <= 1'b1;
                end else if (cyc_q == CYC_PER_MS - 1) begin
                    cyc_q <= 32'h0;
                    ms_q  <= ms_q + 16'h1;
                end else begin
                    cyc_q <= cyc_q + 32'h1;
                end
            end
        end
    end
endmodule

/* core/mbsf_top.v */
`timescale 1ns/10ps
`include "mbsf_map.vh"
// ----------------------------------------
// Response logic: address match, unmapped handling, formatting
// ----------------------------------------
// A parsed request arrives as req_valid_in with fields; the point lookup
// (outside) supplies mapping, value, status and per-point scale data.
module mbsf_top #(
    parameter CYC_PER_MS = `MBSF_CYC_PER_MS
) (
    input  wire        clock_in,
    input  wire        nrst_in,
    input  wire        ce_in,
    // Configuration
    input  wire        multi_addr_in,
    input  wire [7:0]  slave_addr_in,
    input  wire [15:0] tcp_port_cfg_in,
    input  wire [15:0] baud_cfg_in,
    input  wire [1:0]  parity_cfg_in,
    input  wire        two_stop_cfg_in,
    input  wire [15:0] delay_ms_in,
    input  wire        unmapped_zero_in,
    input  wire [1:0]  format_in,
    input  wire        swap_in,
    input  wire        status_err_in,
    input  wire [1:0]  err_float_sel_in,
    input  wire [31:0] err_float_user_in,
    input  wire [15:0] err_int_user_in,
    input  wire [15:0] max_int_in,
    input  wire        global_scale_in,
    input  wire [31:0] global_gain_in,
    input  wire [31:0] global_offset_in,
    // Parsed request
    input  wire        req_valid_in,
    input  wire        req_tcp_in,
    input  wire [15:0] req_port_in,
    input  wire [7:0]  req_addr_in,
    input  wire        req_write_in,
    input  wire        req_discrete_in,
    input  wire        req_word_lo_in,
    input  wire [4:0]  req_bit_count_in,
    // Point lookup
    input  wire        pt_mapped_in,
    input  wire [7:0]  pt_addr_in,
    input  wire [31:0] pt_value_in,
    input  wire        pt_critical_in,
    input  wire [31:0] pt_gain_in,
    input  wire [31:0] pt_offset_in,
    input  wire [15:0] pt_bits_in,
    // Link configuration to the serial layer
    output wire [15:0] baud_out,
    output wire [1:0]  parity_out,
    output wire        two_stop_out,
    // Response
    output reg         rsp_valid_out,
    output reg  [15:0] rsp_data_out,
    output reg         drop_out
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;

    reg  [1:0]  state_q;
    reg  [15:0] data_q;
    wire        addr_ok;
    wire        start;
    wire        done;
    wire [31:0] gain;
    wire [31:0] offset;
    wire [15:0] round_v;
    wire [15:0] scale_v;
    reg  [31:0] fval;
    reg  [15:0] word_v;
    reg  [15:0] bits_v;
    reg         silent_v;

    // ----------------------------------------
    // Serial settings passed through
    // ----------------------------------------
    assign baud_out     = baud_cfg_in;
    assign parity_out   = parity_cfg_in;
    assign two_stop_out = two_stop_cfg_in;

    // Address or port match
    assign addr_ok = req_tcp_in ? (req_port_in == tcp_port_cfg_in)
                   : multi_addr_in ? (req_addr_in == pt_addr_in)
                   : (req_addr_in == slave_addr_in);
    assign start = req_valid_in && addr_ok && state_q == ST_IDLE;

    // Gain and offset selection
    assign gain   = global_scale_in ? global_gain_in : pt_gain_in;
    assign offset = global_scale_in ? global_offset_in : pt_offset_in;

    mbsf_conv u_conv (
        .value_in   (pt_value_in),
        .gain_in    (gain),
        .offset_in  (offset),
        .max_int_in (max_int_in),
        .round_out  (round_v),
        .scale_out  (scale_v)
    );

    mbsf_delay #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_delay (
        .clock_in    (clock_in),
        .nrst_in     (nrst_in),
        .ce_in       (ce_in),
        .start_in    (start && !silent_v),
        .delay_ms_in (delay_ms_in),
        .done_out    (done)
    );

    // Response word selection
    always @* begin
        case (err_float_sel_in)
            `MBSF_ERR_NAN:  fval = `MBSF_F32_NAN;
            `MBSF_ERR_PINF: fval = `MBSF_F32_PINF;
            `MBSF_ERR_NINF: fval = `MBSF_F32_NINF;
            default:        fval = err_float_user_in;
        endcase
        if (!(status_err_in && pt_critical_in))
            fval = pt_value_in;
        bits_v = (req_bit_count_in == 5'h0 || req_bit_count_in >= 5'h10) ? pt_bits_in
               : (pt_bits_in << (5'h10 - req_bit_count_in));
        silent_v = req_write_in ? !pt_mapped_in
                 : (!pt_mapped_in && !unmapped_zero_in);
        if (!pt_mapped_in)
            word_v = 16'h0000;
        else if (req_discrete_in)
            word_v = bits_v;
        else if (format_in == `MBSF_FMT_FLOAT)
            word_v = (req_word_lo_in ^ swap_in) ? fval[15:0] : fval[31:16];
        else if (status_err_in && pt_critical_in)
            word_v = err_int_user_in;
        else if (format_in == `MBSF_FMT_ROUND)
            word_v = round_v;
        else
            word_v = scale_v;
    end

    // ----------------------------------------
    // Request/delay/response sequencer
    // ----------------------------------------
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q       <= ST_IDLE;
            data_q        <= 16'h0000;
            rsp_valid_out <= 1'b0;
            rsp_data_out  <= 16'h0000;
            drop_out      <= 1'b0;
        end else if (ce_in) begin
            rsp_valid_out <= 1'b0;
            drop_out      <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        if (silent_v) begin
                            drop_out <= 1'b1;
                        end else begin
                            data_q  <= word_v;
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (done) begin
                        rsp_valid_out <= 1'b1;
                        rsp_data_out  <= data_q;
                        state_q       <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

/* testbench/mbsf_host.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Host model: issues one parsed request, waits for the answer
// ----------------------------------------
module mbsf_host (
    input  wire        clock_in,
    input  wire        rsp_valid_in,
    input  wire        drop_in,
    input  wire [15:0] rsp_data_in,
    output logic       req_valid_out = 1'b0,
    output logic       req_tcp_out = 1'b0,
    output logic       req_write_out = 1'b0,
    output logic       req_discrete_out = 1'b0,
    output logic       req_word_lo_out = 1'b0,
    output logic [15:0] req_port_out = 16'h0000,
    output logic [7:0] req_addr_out = 8'h00,
    output logic [4:0] req_bit_count_out = 5'h00
);
    // One request at a time; k is 0 none, 1 answer, 2 dropped
    task automatic xfer(input logic t, w, d, lo, input logic [15:0] p, input logic [7:0] a,
                        input logic [4:0] n, output logic [1:0] k, output logic [15:0] q, output int c);
        k = 2'h0;
        q = 16'h0000;
        c = 0;
        @(posedge clock_in);
        req_valid_out <= 1'b1;
        {req_tcp_out, req_write_out, req_discrete_out, req_word_lo_out} <= {t, w, d, lo};
        {req_port_out, req_addr_out, req_bit_count_out} <= {p, a, n};
        @(posedge clock_in);
        req_valid_out <= 1'b0;
        req_addr_out <= ~a; // Released address and port stop showing the old value
        req_port_out <= ~p;
        while (k == 2'h0 && c < 400) begin
            #1;
            if (drop_in === 1'b1) k = 2'h2;
            else if (rsp_valid_in === 1'b1) begin
                k = 2'h1;
                q = rsp_data_in;
            end else begin
                c++;
                @(posedge clock_in);
            end
        end
    endtask
endmodule

/* testbench/mbsf_top_sva.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Checker on the response logic ports
// ----------------------------------------
module mbsf_chk #(parameter CYC_PER_MS = 4) (
    input wire clock_in, nrst_in, ce_in, multi_addr_in, two_stop_cfg_in, unmapped_zero_in,
    input wire status_err_in, req_valid_in, req_tcp_in, req_write_in, req_discrete_in, pt_mapped_in, pt_critical_in,
    input wire [7:0] slave_addr_in, req_addr_in, pt_addr_in,
    input wire [15:0] tcp_port_cfg_in, baud_cfg_in, delay_ms_in, err_int_user_in, req_port_in,
    input wire [1:0] parity_cfg_in, format_in, parity_out,
    input wire [15:0] baud_out, rsp_data_out,
    input wire two_stop_out, rsp_valid_out, drop_out
);
    // Address or port match and outstanding request
    wire hit = req_tcp_in ? (req_port_in == tcp_port_cfg_in)
                          : (req_addr_in == (multi_addr_in ? pt_addr_in : slave_addr_in));
    reg  busy_q;
    wire take = req_valid_in & ce_in & hit & !busy_q;
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) busy_q <= 1'b0;
        else if (take) busy_q <= 1'b1;
        else if (rsp_valid_out | drop_out) busy_q <= 1'b0;
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    sequence s_zero_rsp;
        ##[1:8] (rsp_valid_out && rsp_data_out == 16'h0000);
    endsequence
    sequence s_err_rsp;
        ##[1:8] (rsp_valid_out && rsp_data_out == err_int_user_in);
    endsequence
    a_zero_fill: assert property (take && !pt_mapped_in && !req_write_in && unmapped_zero_in
        && delay_ms_in == 16'h0000 |-> s_zero_rsp) else $error("zero fill answer missing");
    a_unmapped_drop: assert property (take && !pt_mapped_in && (req_write_in || !unmapped_zero_in)
        |=> drop_out) else $error("unmapped request not dropped");
    a_drop_pulse: assert property (drop_out |=> !drop_out && !rsp_valid_out) else $error("drop not a pulse");
    a_rsp_pulse: assert property (rsp_valid_out |=> !rsp_valid_out) else $error("answer not a pulse");
    a_delay_hold: assert property (take && delay_ms_in == 16'h0002 |=> !rsp_valid_out [*8])
        else $error("answer before delay");
    a_err_int: assert property (take && pt_mapped_in && status_err_in && pt_critical_in
        && format_in != 2'h0 && !req_discrete_in && delay_ms_in == 16'h0000 |-> s_err_rsp)
        else $error("integer error value missing");
    a_link_copy: assert property (baud_out == baud_cfg_in && parity_out == parity_cfg_in
        && two_stop_out == two_stop_cfg_in) else $error("link settings not passed on");
    a_quiet_miss: assert property (req_valid_in && !hit && !busy_q |=> !drop_out && !rsp_valid_out)
        else $error("foreign request answered");
endmodule

bind mbsf_top mbsf_chk #(.CYC_PER_MS(CYC_PER_MS)) i_chk (.*);

/* testbench/tb.sv */
`timescale 1ns/10ps
module tb;
    typedef struct packed {logic [1:0] f; logic [3:0] b; logic [1:0] es; logic [31:0] v; logic [15:0] mx, ex;} mbsf_row_t;
    logic clock_in = 1'b0, nrst_in = 1'b0, ce_in = 1'b1, multi_addr_in = 1'b0, two_stop_cfg_in = 1'b1;
    logic unmapped_zero_in = 1'b1, swap_in = 1'b0, status_err_in = 1'b1, global_scale_in = 1'b1;
    logic pt_mapped_in = 1'b1, pt_critical_in = 1'b0;
    logic [7:0] slave_addr_in = 8'h11, pt_addr_in = 8'h22;
    logic [15:0] tcp_port_cfg_in = 16'h01F6, baud_cfg_in = 16'h2580, delay_ms_in = 16'h0000;
    logic [15:0] err_int_user_in = 16'hABCD, max_int_in = 16'hFFFE, pt_bits_in = 16'h000A;
    logic [1:0] parity_cfg_in = 2'h1, format_in = 2'h0, err_float_sel_in = 2'h0;
    logic [31:0] err_float_user_in = 32'h12345678, global_gain_in = 32'h00010000, global_offset_in = 32'h00008000;
    logic [31:0] pt_value_in = 32'hC2C877CF, pt_gain_in = 32'h00020000, pt_offset_in = 32'h00008000;
    wire req_valid_in, req_tcp_in, req_write_in, req_discrete_in, req_word_lo_in, two_stop_out, rsp_valid_out, drop_out;
    wire [15:0] req_port_in, baud_out, rsp_data_out;
    wire [7:0] req_addr_in;
    wire [4:0] req_bit_count_in;
    wire [1:0] parity_out;
    logic [1:0] k;
    logic [15:0] q;
    int c, i, err_count = 0, comparisons = 0;
    mbsf_row_t rows [13];
    mbsf_top #(.CYC_PER_MS(4)) i_dut (.*);
    mbsf_host i_host (.clock_in(clock_in), .rsp_valid_in(rsp_valid_out), .drop_in(drop_out),
        .rsp_data_in(rsp_data_out), .req_valid_out(req_valid_in), .req_tcp_out(req_tcp_in),
        .req_write_out(req_write_in), .req_discrete_out(req_discrete_in), .req_word_lo_out(req_word_lo_in),
        .req_port_out(req_port_in), .req_addr_out(req_addr_in), .req_bit_count_out(req_bit_count_in));
    // Clock and watchdog
    initial begin
        forever #2.5 clock_in = ~clock_in;
    end
    initial begin
        #100000;
        err_count++;
        print_verdict;
    end
    task automatic cmp(input logic [31:0] g, e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic run(input logic t, w, d, lo, input logic [15:0] p, input logic [7:0] a,
                       input logic [4:0] n, input logic [17:0] e);
        i_host.xfer(t, w, d, lo, p, a, n, k, q, c);
        cmp({k, q}, e);
        $display("test done at %0t", $time);
    endtask
    task automatic print_verdict;
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Rows: format, {swap, low word, global, critical}, error pick, value, max, expected word
    initial begin
        rows[0] = '{2'h0, 4'h2, 2'h0, 32'hC2C877CF, 16'hFFFE, 16'hC2C8};
        rows[1] = '{2'h0, 4'h6, 2'h0, 32'hC2C877CF, 16'hFFFE, 16'h77CF};
        rows[2] = '{2'h0, 4'hA, 2'h0, 32'hC2C877CF, 16'hFFFE, 16'h77CF};
        rows[3] = '{2'h0, 4'hE, 2'h0, 32'hC2C877CF, 16'hFFFE, 16'hC2C8};
        rows[4] = '{2'h1, 4'h2, 2'h0, 32'h45297F94, 16'hFFFE, 16'h0A98};
        rows[5] = '{2'h2, 4'h2, 2'h0, 32'h42C80000, 16'hFFFE, 16'h0064};
        rows[6] = '{2'h2, 4'h0, 2'h0, 32'h42C80000, 16'hFFFE, 16'h00C8};
        rows[7] = '{2'h2, 4'h2, 2'h0, 32'h42C80000, 16'h0032, 16'h0032};
        rows[8] = '{2'h0, 4'h3, 2'h0, 32'hC2C877CF, 16'hFFFE, 16'h7FC0};
        rows[9] = '{2'h0, 4'h3, 2'h1, 32'hC2C877CF, 16'hFFFE, 16'h7F80};
        rows[10] = '{2'h0, 4'h3, 2'h2, 32'hC2C877CF, 16'hFFFE, 16'hFF80};
        rows[11] = '{2'h0, 4'h3, 2'h3, 32'hC2C877CF, 16'hFFFE, 16'h1234};
        rows[12] = '{2'h1, 4'h3, 2'h0, 32'h45297F94, 16'hFFFE, 16'hABCD};
        repeat (12) @(posedge clock_in);
        nrst_in <= 1'b1;
        @(posedge clock_in);
        #1;
        cmp({rsp_valid_out, drop_out, rsp_data_out}, 18'h0);
        cmp({baud_out, parity_out, two_stop_out}, {16'h2580, 2'h1, 1'b1});
        $display("test done at %0t", $time);
        for (i = 0; i < 13; i++) begin
            @(posedge clock_in);
            {format_in, swap_in, global_scale_in, pt_critical_in} <= {rows[i].f, rows[i].b[3], rows[i].b[1:0]};
            {err_float_sel_in, pt_value_in, max_int_in} <= {rows[i].es, rows[i].v, rows[i].mx};
            run(1'b0, 1'b0, 1'b0, rows[i].b[2], 16'h0000, 8'h11, 5'h00, {2'h1, rows[i].ex});
        end
        // Address selection, TCP port and discrete packing
        @(posedge clock_in);
        {pt_critical_in, max_int_in} <= {1'b0, 16'hFFFE};
        run(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h12, 5'h00, 18'h0);
        @(posedge clock_in);
        multi_addr_in <= 1'b1;
        run(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h22, 5'h00, {2'h1, 16'h0A98});
        run(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h11, 5'h00, 18'h0);
        run(1'b1, 1'b0, 1'b0, 1'b0, 16'h01F6, 8'h00, 5'h00, {2'h1, 16'h0A98});
        run(1'b1, 1'b0, 1'b0, 1'b0, 16'h01F7, 8'h00, 5'h00, 18'h0);
        run(1'b0, 1'b0, 1'b1, 1'b0, 16'h0000, 8'h22, 5'h04, {2'h1, 16'hA000});
        run(1'b0, 1'b0, 1'b1, 1'b0, 16'h0000, 8'h22, 5'h10, {2'h1, 16'h000A});
        // Response delay of 2 ms at 4 cycles each
        @(posedge clock_in);
        delay_ms_in <= 16'h0002;
        run(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h22, 5'h00, {2'h1, 16'h0A98});
        cmp(c >= 8 && c <= 16, 1);
        // Reset during the wait drops the pending answer
        fork
            run(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h22, 5'h00, 18'h0);
            begin
                repeat (4) @(posedge clock_in);
                nrst_in <= 1'b0;
                repeat (2) @(posedge clock_in);
                nrst_in <= 1'b1;
            end
        join
        // Unmapped reads and writes
        @(posedge clock_in);
        {delay_ms_in, pt_mapped_in} <= {16'h0000, 1'b0};
        run(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h22, 5'h00, {2'h1, 16'h0000});
        run(1'b0, 1'b1, 1'b0, 1'b0, 16'h0000, 8'h22, 5'h00, {2'h2, 16'h0000});
        @(posedge clock_in);
        unmapped_zero_in <= 1'b0;
        run(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h22, 5'h00, {2'h2, 16'h0000});
        print_verdict;
    end
endmodule
